/* File: common/adc_regmap_pkg.sv */
package adc_regmap_pkg;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CONTROL = 6'h01;
  localparam logic [5:0] ADDR_RESULT = 6'h02;
  localparam logic [5:0] ADDR_PIN = 6'h03;
  localparam logic [5:0] ADDR_BIAS = 6'h04;
  localparam logic [5:0] ADDR_IDENT = 6'h05;
  localparam logic [5:0] ADDR_FAULT = 6'h06;
  localparam logic [5:0] ADDR_FAULT_EN = 6'h07;
  localparam logic [5:0] ADDR_TALLY = 6'h08;
  localparam logic [5:0] ADDR_CHAN = 6'h09;
  localparam logic [5:0] ADDR_CFG = 6'h19;
  localparam logic [5:0] ADDR_FILT = 6'h21;
  localparam logic [5:0] ADDR_ZERO = 6'h29;
  localparam logic [5:0] ADDR_SCALE = 6'h31;
  localparam logic [5:0] ADDR_MISC = 6'h39;
  localparam logic [5:0] ADDR_QCTL = 6'h3a;
  localparam logic [5:0] ADDR_QSTATE = 6'h3b;
  localparam logic [5:0] ADDR_QLIMIT = 6'h3c;
  localparam logic [5:0] ADDR_QOUT = 6'h3d;
  localparam int CHAN_COUNT = 16;
  localparam int SETUP_COUNT = 8;
  localparam logic [7:0] RST_STATUS = 8'h10;
  localparam logic [15:0] RST_CONTROL = 16'h4000;
  localparam logic [15:0] RST_FAULT_EN = 16'h0040;
  localparam logic [23:0] RST_CHAN0 = 24'h800100;
  localparam logic [23:0] RST_CHAN = 24'h000100;
  localparam logic [23:0] RST_FILT = 24'h002030;
  localparam logic [23:0] RST_ZERO = 24'h008000;
  localparam logic [23:0] RST_QCTL = 24'h040200;
  localparam logic [7:0] RST_QSTATE = 8'h01;
  localparam logic [23:0] RST_QLIMIT = 24'hfff000;
  // Nominal trim; the real value comes from factory calibration.
  localparam logic [23:0] RST_SCALE = 24'h005555;
  // Identification value is arbitrary.
  localparam logic [7:0] PART_ID = 8'h3c;
  localparam logic [15:0] CONTROL_WMASK = 16'h7f7f;
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_READ_BIT = 6;
  localparam int FAULT_IGNORE_BIT = 6;
  localparam int STATUS_FAULT_BIT = 6;
  localparam int SOFT_RESET_ONES = 64;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_DELAY_NS = 1000;
  localparam int INIT_CYCLES = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_DROP = 4'b1000
  } serial_state_t;
endpackage : adc_regmap_pkg

/* File: logic/adc_register_map_init.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_register_map_init #(
  parameter int INIT_WAIT = adc_regmap_pkg::INIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic device_ready,
  output logic [15:0] converter_settings,
  output logic [15:0] pin_settings
);
  import adc_regmap_pkg::*;

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic din;
  logic bit_in;
  logic soft_reset;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in({sdi, cs_n, sclk}),
    .pin_level(pin_level),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign cs_active = ~pin_level[1];
  assign din = pin_level[2];
  assign bit_in = sclk_rise & cs_active;

  ones_detect u_ones (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .bit_strobe(bit_in),
    .bit_value(din),
    .soft_reset(soft_reset)
  );

  // Bytes moved by a register; unmapped addresses act as one zero byte.
  function automatic logic [1:0] reg_len(input logic [5:0] a);
    if (a == ADDR_STATUS || a == ADDR_IDENT || a == ADDR_TALLY ||
        a == ADDR_QSTATE) begin
      reg_len = 2'd1;
    end else if (a == ADDR_CONTROL || a == ADDR_PIN || a == ADDR_BIAS ||
                 a == ADDR_FAULT || a == ADDR_FAULT_EN || a == ADDR_MISC ||
                 (a >= ADDR_CFG && a < ADDR_FILT)) begin
      reg_len = 2'd2;
    end else if (a <= ADDR_QOUT) begin
      reg_len = 2'd3;
    end else begin
      reg_len = 2'd1;
    end
  endfunction : reg_len

  function automatic logic in_bank(input logic [5:0] a,
                                   input logic [5:0] base,
                                   input int size);
    in_bank = (a >= base) && (a < base + 6'(size));
  endfunction : in_bank

  // Configuration storage.
  logic [15:0] control;
  logic [15:0] pin_ctl;
  logic [15:0] bias;
  logic [15:0] fault;
  logic [15:0] fault_en;
  logic [15:0] misc;
  logic [23:0] qctl;
  logic [23:0] qlimit;
  logic [23:0] chan [CHAN_COUNT];
  logic [15:0] cfg [SETUP_COUNT];
  logic [23:0] filt [SETUP_COUNT];
  logic [23:0] zero [SETUP_COUNT];
  logic [23:0] scale [SETUP_COUNT];
  logic [15:0] next_control;
  logic [15:0] next_pin_ctl;
  logic [15:0] next_bias;
  logic [15:0] next_fault;
  logic [15:0] next_fault_en;
  logic [15:0] next_misc;
  logic [23:0] next_qctl;
  logic [23:0] next_qlimit;
  logic [23:0] next_chan [CHAN_COUNT];
  logic [15:0] next_cfg [SETUP_COUNT];
  logic [23:0] next_filt [SETUP_COUNT];
  logic [23:0] next_zero [SETUP_COUNT];
  logic [23:0] next_scale [SETUP_COUNT];

  // Serial engine state.
  serial_state_t state;
  serial_state_t next_state;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [23:0] shift_in;
  logic [23:0] next_shift_in;
  logic [23:0] shift_out;
  logic [23:0] next_shift_out;
  logic [5:0] cur_addr;
  logic [5:0] next_cur_addr;
  logic next_sdo;
  logic next_sdo_oe;
  logic [15:0] init_cnt;
  logic [15:0] next_init_cnt;
  logic next_device_ready;

  // Decoded events of the serial engine.
  logic [23:0] word_in;
  logic [7:0] cmd_in;
  logic [4:0] word_bits;
  logic write_done;
  logic early_access;
  logic [23:0] rd_value;
  logic [3:0] ci;
  logic [2:0] si;

  assign word_in = {shift_in[22:0], din};
  assign cmd_in = word_in[7:0];
  assign word_bits = {reg_len(cur_addr), 3'b000};
  assign write_done = (state == ST_WRITE) && bit_in &&
                      (bit_cnt == word_bits - 5'd1);
  assign early_access = (state == ST_CMD) && bit_in && (bit_cnt == 5'd7) &&
                        !device_ready;

  // Read value of the addressed register, left in the low bits.
  always_comb begin
    rd_value = 24'h000000;
    ci = 4'(cmd_in[5:0] - ADDR_CHAN);
    si = 3'(cmd_in[5:0] - ADDR_CFG);
    if (in_bank(cmd_in[5:0], ADDR_CHAN, CHAN_COUNT)) begin
      rd_value = chan[ci];
    end else if (in_bank(cmd_in[5:0], ADDR_CFG, SETUP_COUNT)) begin
      rd_value = {8'h00, cfg[si]};
    end else if (in_bank(cmd_in[5:0], ADDR_FILT, SETUP_COUNT)) begin
      rd_value = filt[si];
    end else if (in_bank(cmd_in[5:0], ADDR_ZERO, SETUP_COUNT)) begin
      rd_value = zero[si];
    end else if (in_bank(cmd_in[5:0], ADDR_SCALE, SETUP_COUNT)) begin
      rd_value = scale[si];
    end else begin
      case (cmd_in[5:0])
        ADDR_STATUS: begin
          rd_value = {16'h0000, RST_STATUS};
          rd_value[STATUS_FAULT_BIT] = |fault;
        end
        ADDR_CONTROL: rd_value = {8'h00, control};
        ADDR_PIN: rd_value = {8'h00, pin_ctl};
        ADDR_BIAS: rd_value = {8'h00, bias};
        ADDR_IDENT: rd_value = {16'h0000, PART_ID};
        ADDR_FAULT: rd_value = {8'h00, fault};
        ADDR_FAULT_EN: rd_value = {8'h00, fault_en};
        ADDR_MISC: rd_value = {8'h00, misc};
        ADDR_QCTL: rd_value = qctl;
        ADDR_QSTATE: rd_value = {16'h0000, RST_QSTATE};
        ADDR_QLIMIT: rd_value = qlimit;
        default: rd_value = 24'h000000;
      endcase
    end
  end

  // Serial framing: command byte, then data bytes, most significant first.
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_cur_addr = cur_addr;
    next_sdo = sdo;
    next_sdo_oe = cs_active;
    if (soft_reset || !cs_active) begin
      next_state = ST_CMD;
      next_bit_cnt = 5'd0;
      next_shift_out = 24'h000000;
      next_sdo = 1'b0;
    end else begin
      if (bit_in) begin
        next_shift_in = word_in;
        next_bit_cnt = bit_cnt + 5'd1;
      end
      if (sclk_fall && state == ST_READ) begin
        next_sdo = shift_out[23];
        next_shift_out = {shift_out[22:0], 1'b0};
      end
      case (state)
        ST_CMD: begin
          if (bit_in && bit_cnt == 5'd7) begin
            next_bit_cnt = 5'd0;
            next_cur_addr = cmd_in[5:0];
            if (early_access || cmd_in[CMD_WEN_BIT]) begin
              next_state = ST_DROP;
            end else if (cmd_in[CMD_READ_BIT]) begin
              next_state = ST_READ;
              next_shift_out = rd_value << (5'd24 - {reg_len(cmd_in[5:0]),
                                                     3'b000});
            end else begin
              next_state = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (write_done) begin
            next_state = ST_CMD;
            next_bit_cnt = 5'd0;
          end
        end
        ST_READ: begin
          if (bit_in && bit_cnt == word_bits - 5'd1) begin
            next_state = ST_CMD;
            next_bit_cnt = 5'd0;
          end
        end
        ST_DROP: begin
          next_bit_cnt = 5'd0;
        end
        default: begin
          next_state = ST_CMD;
          next_bit_cnt = 5'd0;
        end
      endcase
    end
  end

  // Power-on and software-reset initialization wait.
  always_comb begin
    next_init_cnt = init_cnt;
    next_device_ready = device_ready;
    if (soft_reset) begin
      next_init_cnt = 16'h0000;
      next_device_ready = 1'b0;
    end else if (!device_ready) begin
      if (init_cnt == 16'(INIT_WAIT - 1)) begin
        next_device_ready = 1'b1;
      end else begin
        next_init_cnt = init_cnt + 16'h0001;
      end
    end
  end

  // Register updates; read-only locations simply have no write path.
  always_comb begin
    next_control = control;
    next_pin_ctl = pin_ctl;
    next_bias = bias;
    next_fault = fault;
    next_fault_en = fault_en;
    next_misc = misc;
    next_qctl = qctl;
    next_qlimit = qlimit;
    next_chan = chan;
    next_cfg = cfg;
    next_filt = filt;
    next_zero = zero;
    next_scale = scale;
    if (soft_reset) begin
      next_control = RST_CONTROL;
      next_pin_ctl = 16'h0000;
      next_bias = 16'h0000;
      next_fault = 16'h0000;
      next_fault_en = RST_FAULT_EN;
      next_misc = 16'h0000;
      next_qctl = RST_QCTL;
      next_qlimit = RST_QLIMIT;
      for (int i = 0; i < CHAN_COUNT; i++) begin
        next_chan[i] = (i == 0) ? RST_CHAN0 : RST_CHAN;
      end
      for (int i = 0; i < SETUP_COUNT; i++) begin
        next_cfg[i] = 16'h0000;
        next_filt[i] = RST_FILT;
        next_zero[i] = RST_ZERO;
        next_scale[i] = RST_SCALE;
      end
    end else begin
      if (write_done) begin
        if (in_bank(cur_addr, ADDR_CHAN, CHAN_COUNT)) begin
          next_chan[4'(cur_addr - ADDR_CHAN)] = word_in;
        end else if (in_bank(cur_addr, ADDR_CFG, SETUP_COUNT)) begin
          next_cfg[3'(cur_addr - ADDR_CFG)] = word_in[15:0];
        end else if (in_bank(cur_addr, ADDR_FILT, SETUP_COUNT)) begin
          next_filt[3'(cur_addr - ADDR_FILT)] = word_in;
        end else if (in_bank(cur_addr, ADDR_ZERO, SETUP_COUNT)) begin
          next_zero[3'(cur_addr - ADDR_ZERO)] = word_in;
        end else if (in_bank(cur_addr, ADDR_SCALE, SETUP_COUNT)) begin
          next_scale[3'(cur_addr - ADDR_SCALE)] = word_in;
        end else begin
          case (cur_addr)
            ADDR_CONTROL: begin
              next_control = (control & ~CONTROL_WMASK) |
                             (word_in[15:0] & CONTROL_WMASK);
            end
            ADDR_PIN: next_pin_ctl = word_in[15:0];
            ADDR_BIAS: next_bias = word_in[15:0];
            ADDR_FAULT_EN: next_fault_en = word_in[15:0];
            ADDR_MISC: next_misc = word_in[15:0];
            ADDR_QCTL: next_qctl = word_in;
            ADDR_QLIMIT: next_qlimit = word_in;
            ADDR_FAULT: begin
              if (word_in[FAULT_IGNORE_BIT]) begin
                next_fault[FAULT_IGNORE_BIT] = 1'b0;
              end
            end
            default: begin
              next_misc = misc;
            end
          endcase
        end
      end
      // A new early access wins over a clear in the same cycle.
      if (early_access) begin
        next_fault[FAULT_IGNORE_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      control <= RST_CONTROL;
      pin_ctl <= 16'h0000;
      bias <= 16'h0000;
      fault <= 16'h0000;
      fault_en <= RST_FAULT_EN;
      misc <= 16'h0000;
      qctl <= RST_QCTL;
      qlimit <= RST_QLIMIT;
      for (int i = 0; i < CHAN_COUNT; i++) begin
        chan[i] <= (i == 0) ? RST_CHAN0 : RST_CHAN;
      end
      for (int i = 0; i < SETUP_COUNT; i++) begin
        cfg[i] <= 16'h0000;
        filt[i] <= RST_FILT;
        zero[i] <= RST_ZERO;
        scale[i] <= RST_SCALE;
      end
    end else if (clk_en) begin
      control <= next_control;
      pin_ctl <= next_pin_ctl;
      bias <= next_bias;
      fault <= next_fault;
      fault_en <= next_fault_en;
      misc <= next_misc;
      qctl <= next_qctl;
      qlimit <= next_qlimit;
      chan <= next_chan;
      cfg <= next_cfg;
      filt <= next_filt;
      zero <= next_zero;
      scale <= next_scale;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ST_CMD;
      bit_cnt <= 5'd0;
      shift_in <= 24'h000000;
      shift_out <= 24'h000000;
      cur_addr <= 6'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      init_cnt <= 16'h0000;
      device_ready <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      cur_addr <= next_cur_addr;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      init_cnt <= next_init_cnt;
      device_ready <= next_device_ready;
    end
  end

  // The control words are themselves flip-flops, so these are registered.
  assign converter_settings = control;
  assign pin_settings = pin_ctl;
endmodule : adc_register_map_init
`default_nettype wire

/* File: logic/ones_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module ones_detect
  import adc_regmap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic bit_strobe,
  input wire logic bit_value,
  output logic soft_reset
);
  logic [6:0] ones;
  logic [6:0] next_ones;
  logic next_soft_reset;
  always_comb begin
    next_ones = ones;
    next_soft_reset = 1'b0;
    if (bit_strobe) begin
      if (!bit_value) begin
        next_ones = 7'h00;
      end else if (ones == 7'(SOFT_RESET_ONES - 1)) begin
        next_ones = 7'h00;
        next_soft_reset = 1'b1;
      end else begin
        next_ones = ones + 7'h01;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ones <= 7'h00;
      soft_reset <= 1'b0;
    end else if (clk_en) begin
      ones <= next_ones;
      soft_reset <= next_soft_reset;
    end
  end
endmodule : ones_detect
`default_nettype wire

/* File: logic/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_level,
  output logic [2:0] pin_rise,
  output logic [2:0] pin_fall
);
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] stage3;
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          stage1[i] <= 1'b1;
          stage2[i] <= 1'b1;
          stage3[i] <= 1'b1;
        end else if (clk_en) begin
          stage1[i] <= pin_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
        end
      end
      assign pin_rise[i] = stage2[i] & ~stage3[i];
      assign pin_fall[i] = ~stage2[i] & stage3[i];
    end
  endgenerate
  assign pin_level = stage2;
endmodule : pin_sync
`default_nettype wire

/* File: testbench/adc_register_map_init_props.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_register_map_init_props #(
  parameter int INIT_WAIT = 40
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic device_ready,
  input wire logic [15:0] converter_settings,
  input wire logic [15:0] pin_settings
);
  import adc_regmap_pkg::*;
  logic [15:0] wait_cnt;
  logic [15:0] next_wait_cnt;
  // Counts enabled cycles spent waiting, so a frozen clock never trips it.
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (!resetn || device_ready) begin
      next_wait_cnt = 16'h0000;
    end else if (clk_en && wait_cnt != 16'hffff) begin
      next_wait_cnt = wait_cnt + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk) begin
    wait_cnt <= next_wait_cnt;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_reset_values: assert property (
    $rose(resetn) |-> !device_ready && !sdo_oe &&
      converter_settings == 16'h4000 && pin_settings == 16'h0000)
    else $error("settings not at reset value after reset");
  a_init_bounded: assert property (
    !device_ready |-> int'(wait_cnt) <= INIT_WAIT + 4)
    else $error("device never became ready");
  a_ready_not_early: assert property (
    $rose(device_ready) |-> int'(wait_cnt) >= INIT_WAIT - 2)
    else $error("device ready before the wait ended");
  a_drop_needs_select: assert property (
    $fell(device_ready) |-> sdo_oe)
    else $error("ready dropped without a selected frame");
  a_oe_follows_select: assert property (
    $fell(cs_n) |-> ##[2:4] sdo_oe)
    else $error("output enable did not follow the select");
  a_soft_reload: assert property (
    $fell(device_ready) |->
      converter_settings == 16'h4000 && pin_settings == 16'h0000)
    else $error("software reset did not reload settings");
  a_ctrl_reserved_zero: assert property (
    converter_settings[15] == 1'b0 && converter_settings[7] == 1'b0)
    else $error("reserved control bit became set");
  a_write_in_frame: assert property (
    $changed(converter_settings) || $changed(pin_settings) |-> sdo_oe)
    else $error("settings changed outside a frame");
  a_early_frozen: assert property (
    !device_ready && !$past(device_ready) |->
      $stable(converter_settings) && $stable(pin_settings))
    else $error("register written before device ready");
endmodule : adc_register_map_init_props
bind adc_register_map_init adc_register_map_init_props #(
  .INIT_WAIT(INIT_WAIT)) adc_register_map_init_props_i (
  .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sclk(sclk),
  .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .device_ready(device_ready), .converter_settings(converter_settings),
  .pin_settings(pin_settings));
`default_nettype wire

/* File: testbench/spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic ref_clk,
  input wire logic sdo,
  output var logic sclk,
  output var logic cs_n,
  output var logic sdi
);
  // Five cycles a level, so the device's pin synchronisers never miss one.
  localparam int HALF = 5;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int nbits,
                       output logic [63:0] rx);
    rx = 64'h0;
    @(negedge ref_clk);
    cs_n <= 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      sclk <= 1'b0;
      sdi <= tx[63 - i];
      repeat (HALF) @(negedge ref_clk);
      rx = {rx[62:0], sdo};
      sclk <= 1'b1;
      repeat (HALF) @(negedge ref_clk);
    end
    // Select stays low past the last rise so the commit lands in the frame.
    repeat (8) @(negedge ref_clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (HALF) @(negedge ref_clk);
  endtask : frame
  task automatic soft_reset();
    logic [63:0] rx;
    frame(64'hffffffffffffffff, 64, rx);
  endtask : soft_reset
endmodule : spi_host_model
`default_nettype wire

/* File: testbench/tb_adc_register_map_init.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_adc_register_map_init;
  import adc_regmap_pkg::*;
  // Long enough that a command byte can land before the device is ready.
  localparam int WAIT = 200;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe, device_ready;
  logic [15:0] converter_settings;
  logic [15:0] pin_settings;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [5:0] cfg_a [6] = '{6'h20, 6'h21, 6'h30, 6'h31, 6'h09, 6'h18};
  logic [23:0] cfg_d [6] = '{24'h00beef, 24'h123456, 24'habcdef,
    24'h654321, 24'h000000, 24'hfedcba};
  always #12.5 ref_clk = ~ref_clk;
  spi_host_model spi_host_model_i (.ref_clk(ref_clk), .sdo(sdo),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  adc_register_map_init #(.INIT_WAIT(WAIT)) adc_register_map_init_i (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .device_ready(device_ready), .converter_settings(converter_settings),
    .pin_settings(pin_settings));
  function automatic int nbytes(input logic [5:0] a);
    case (a)
      6'h00, 6'h05, 6'h08, 6'h3b: return 1;
      6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h39: return 2;
      default: return (a > 6'h3d) ? 1 : (a >= 6'h19 && a < 6'h21) ? 2 : 3;
    endcase
  endfunction : nbytes
  function automatic logic [23:0] reset_of(input logic [5:0] a);
    if (a >= 6'h09 && a < 6'h19) return (a == 6'h09) ? 24'h800100 : 24'h000100;
    if (a >= 6'h21 && a < 6'h29) return 24'h002030;
    if (a >= 6'h29 && a < 6'h31) return 24'h008000;
    if (a >= 6'h31 && a < 6'h39) return 24'h005555;
    case (a)
      6'h00: return 24'h000010;
      6'h01: return 24'h004000;
      6'h05: return {16'h0000, PART_ID};
      6'h07: return 24'h000040;
      6'h3a: return 24'h040200;
      6'h3b: return 24'h000001;
      6'h3c: return 24'hfff000;
      default: return 24'h000000;
    endcase
  endfunction : reset_of
  task automatic check(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [63:0] rx;
    int n;
    n = nbytes(a);
    d = d & (24'hffffff >> (24 - 8 * n));
    spi_host_model_i.frame({2'b00, a, 56'h0} | ({40'h0, d} << (56 - 8 * n)),
      8 + 8 * n, rx);
  endtask : wr
  task automatic expect_reg(input logic [5:0] a, input logic [23:0] e);
    logic [63:0] rx;
    int n;
    n = nbytes(a);
    spi_host_model_i.frame({2'b01, a, 56'h0}, 8 + 8 * n, rx);
    check(rx[23:0] & (24'hffffff >> (24 - 8 * n)), e);
  endtask : expect_reg
  task automatic scan();
    for (int i = 0; i < 64; i++) begin
      // The tally is skipped, although the device always reads it as zero.
      if (i != 8) begin
        expect_reg(6'(i), reset_of(6'(i)));
      end
    end
  endtask : scan
  task automatic wait_ready();
    int k;
    k = 0;
    while (device_ready !== 1'b1 && k < 4 * WAIT) begin
      @(negedge ref_clk);
      k++;
    end
    check({23'h0, device_ready}, 24'h000001);
  endtask : wait_ready
  task automatic done(input string s);
    $display("test %s ended", s);
  endtask : done
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn <= 1'b1;
    // Sent on purpose before the device is ready.
    wr(6'h01, 24'h001234);
    wait_ready();
    check({8'h0, converter_settings}, 24'h004000);
    expect_reg(6'h06, 24'h000040);
    expect_reg(6'h00, 24'h000050);
    wr(6'h06, 24'h000000);
    expect_reg(6'h06, 24'h000040);
    wr(6'h06, 24'h000040);
    expect_reg(6'h06, 24'h000000);
    done("early access");
    scan();
    done("reset table");
    wr(6'h00, 24'h0000ff);
    wr(6'h05, 24'h0000ff);
    wr(6'h02, 24'hffffff);
    expect_reg(6'h00, 24'h000010);
    expect_reg(6'h05, {16'h0000, PART_ID});
    expect_reg(6'h02, 24'h000000);
    wr(6'h01, 24'h00ffff);
    check({8'h0, converter_settings}, 24'h007f7f);
    for (int i = 0; i < 6; i++) begin
      wr(cfg_a[i], cfg_d[i]);
    end
    wr(6'h01, 24'h000123);
    check({8'h0, converter_settings}, 24'h000123);
    wr(6'h03, 24'h00a5c3);
    check({8'h0, pin_settings}, 24'h00a5c3);
    for (int i = 0; i < 6; i++) begin
      expect_reg(cfg_a[i], cfg_d[i]);
    end
    done("access kinds");
    spi_host_model_i.soft_reset();
    check({23'h0, device_ready}, 24'h000000);
    check({8'h0, converter_settings}, 24'h004000);
    check({8'h0, pin_settings}, 24'h000000);
    clk_en <= 1'b0;
    repeat (WAIT + 20) @(negedge ref_clk);
    check({23'h0, device_ready}, 24'h000000);
    clk_en <= 1'b1;
    wait_ready();
    scan();
    done("software reset");
    close_out();
  end
endmodule : tb_adc_register_map_init
`default_nettype wire
